// file: inc/cis_pkg.sv
// Constants, opcodes and carriers for the core state and interrupt sequencer.
// Assumes an 8 Kbyte map, byte-wide memory with read data one cycle after the strobe.
package cis_pkg;

  // ==========================================================================
  // Address map
  localparam logic [12:0] IO_LO      = 13'h0000;
  localparam logic [12:0] IO_HI      = 13'h001F;
  localparam logic [12:0] PZ_ROM_LO  = 13'h0020;
  localparam logic [12:0] PZ_ROM_HI  = 13'h004F;
  localparam logic [12:0] RAM_LO     = 13'h0080;
  localparam logic [12:0] RAM_HI     = 13'h00FF;
  localparam logic [12:0] MAIN_ROM_LO = 13'h0100;
  localparam logic [12:0] MAIN_ROM_HI = 13'h08FF;
  localparam logic [12:0] SELF_LO    = 13'h1F00;
  localparam logic [12:0] SELF_HI    = 13'h1FEF;
  localparam logic [12:0] UVEC_LO    = 13'h1FF0;
  localparam logic [12:0] UVEC_HI    = 13'h1FFF;

  // ==========================================================================
  // Vectors (high byte first, low byte at the next address)
  localparam logic [12:0] VEC_RESET  = 13'h1FFE;
  localparam logic [12:0] VEC_TRAP   = 13'h1FFC;
  localparam logic [12:0] VEC_EXT    = 13'h1FFA;
  localparam logic [12:0] VEC_TIMER  = 13'h1FF8;

  // ==========================================================================
  // Stack
  localparam logic [6:0]  STK_UPPER  = 7'h03;
  localparam logic [5:0]  SP_TOP     = 6'h3F;
  localparam logic [2:0]  CALL_BYTES = 3'h2;
  localparam logic [2:0]  INT_BYTES  = 3'h5;

  // ==========================================================================
  // Flag bit positions
  localparam int FL_H = 4;
  localparam int FL_I = 3;
  localparam int FL_N = 2;
  localparam int FL_Z = 1;
  localparam int FL_C = 0;
  localparam logic [4:0] FLAGS_RST = 5'h08;

  // ==========================================================================
  // Software register port
  localparam logic [3:0] R_CTRL  = 4'h0;
  localparam logic [3:0] R_ACC   = 4'h1;
  localparam logic [3:0] R_IDX   = 4'h2;
  localparam logic [3:0] R_FLAGS = 4'h3;
  localparam logic [3:0] R_SP    = 4'h4;
  localparam logic [3:0] R_PCH   = 4'h5;
  localparam logic [3:0] R_PCL   = 4'h6;
  localparam logic [3:0] R_STAT  = 4'h7;
  localparam int CTRL_EXT_EN = 0;

  typedef enum logic [4:0] {
    OP_NOP  = 5'h00, OP_LDA  = 5'h01, OP_LDX  = 5'h02, OP_ADD  = 5'h03,
    OP_ADC  = 5'h04, OP_SUB  = 5'h05, OP_SBC  = 5'h06, OP_AND  = 5'h07,
    OP_ORA  = 5'h08, OP_EOR  = 5'h09, OP_LSL  = 5'h0A, OP_LSR  = 5'h0B,
    OP_ROL  = 5'h0C, OP_ROR  = 5'h0D, OP_BTST = 5'h0E, OP_FETCH = 5'h0F,
    OP_JUMP = 5'h10, OP_CALL = 5'h11, OP_RET  = 5'h12, OP_TRAP = 5'h13,
    OP_IRET = 5'h14, OP_SPRL = 5'h15, OP_CLI  = 5'h16, OP_SEI  = 5'h17
  } cis_op_t;

  typedef enum logic [2:0] {
    S_RUN     = 3'b000,
    S_PUSH    = 3'b001,
    S_PULL_RQ = 3'b010,
    S_PULL_CP = 3'b011,
    S_VEC_RQ  = 3'b100,
    S_VEC_CP  = 3'b101
  } cis_state_t;

  typedef struct packed {
    cis_op_t     op;
    logic [7:0]  operand;
    logic [12:0] target;
  } cis_cmd_t;

  typedef struct packed {
    logic io;
    logic ram;
    logic user_rom;
    logic user_vec;
    logic self_rom;
  } cis_region_t;

endpackage : cis_pkg

// file: rtl/cis_core_state.sv
// Programmer-visible core state, stack engine and interrupt sequencer.
// Assumes an instruction decoder issues one command per cycle while BUSY is low,
// and memory returns read data in the cycle after MEM_RE.
// What this block does
// RULE_01: User ROM in three decoded regions
// RULE_02: Self-check ROM decoded at its range
// RULE_03: 128-byte RAM, stack grows down from top
// RULE_04: Eight-bit accumulator holds operands, results
// RULE_05: Eight-bit index register, also scratch
// RULE_06: Five-bit flags, each visible for branching
// RULE_07: Half carry from bit 3 on adds
// RULE_08: Mask blocks timer/external; external request stays latched
// RULE_09: Negative and zero follow each result
// RULE_10: Carry from ALU, bit test, shifts
// RULE_11: Reset and reload set stack pointer top
// RULE_12: Push then decrement, increment then pull
// RULE_13: Six counting stack bits, wrap at 64
// RULE_14: Call pushes two, interrupt pushes five
// RULE_15: Thirteen-bit program counter, next fetch address
// RULE_16: Entry stacks registers, sets mask; return restores
// RULE_17: Requests wait for the current instruction
// RULE_18: Boundary check honours mask and source enable
// RULE_19: External request beats timer request
// RULE_20: Software trap ignores the mask
// RULE_21: Fixed vector addresses per source
// RULE_22: Address registers truncated to 8 Kbyte
// RULE_23: External latch clears on service entry
// RULE_24: Timer request is any enabled timer flag
// RULE_25: Stack order PCL, PCH, X, A, flags
`timescale 1ns/1ps
`default_nettype none

module cis_core_state (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 CMD_VALID,
  input  wire cis_pkg::cis_cmd_t    CMD,
  input  wire logic                 BOUNDARY,
  input  wire logic                 EXT_REQ,
  input  wire logic [2:0]           TMR_FLAGS,
  input  wire logic [2:0]           TMR_EN,
  input  wire logic [7:0]           MEM_RDATA,
  output logic      [12:0]          MEM_ADDR,
  output logic      [7:0]           MEM_WDATA,
  output logic                      MEM_WE,
  output logic                      MEM_RE,
  output cis_pkg::cis_region_t      MEM_REGION,
  output logic                      BUSY,
  output logic                      INT_ACK,
  output logic      [4:0]           FLAGS,
  output logic      [7:0]           ACC,
  output logic      [7:0]           IDX,
  input  wire logic [3:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [7:0]           REG_RDATA
);
  import cis_pkg::*;

  // ==========================================================================
  // Address decode
  // RULE_01 user ROM regions
  // RULE_02 self-check range
  function automatic cis_region_t decode_region(input logic [12:0] a);
    cis_region_t r;
    r.io       = (a <= IO_HI);
    r.ram      = (a >= RAM_LO) && (a <= RAM_HI);
    r.user_rom = ((a >= PZ_ROM_LO) && (a <= PZ_ROM_HI)) ||
                 ((a >= MAIN_ROM_LO) && (a <= MAIN_ROM_HI)) ||
                 (a >= UVEC_LO);
    r.user_vec = (a >= UVEC_LO) && (a <= UVEC_HI);
    r.self_rom = (a >= SELF_LO) && (a <= SELF_HI);
    return r;
  endfunction : decode_region

  // ==========================================================================
  // State
  cis_state_t  state_ff,  nxt_state;
  logic [7:0]  acc_ff,    nxt_acc;
  logic [7:0]  idx_ff,    nxt_idx;
  logic [4:0]  flags_ff,  nxt_flags;
  logic [5:0]  sp_ff,     nxt_sp;
  logic [12:0] pc_ff,     nxt_pc;
  logic [12:0] vec_ff,    nxt_vec;
  logic [2:0]  step_ff,   nxt_step;
  logic [2:0]  count_ff,  nxt_count;
  logic        jump_ff,   nxt_jump;
  logic        ext_lat_ff;
  logic        ext_en_ff;
  logic [7:0]  rdata_ff;
  logic        ack_ff;

  wire         run       = (state_ff == S_RUN);
  wire         cmd_go    = CMD_VALID && run;
  wire cis_op_t op       = CMD.op;
  wire [7:0]   opd       = CMD.operand;
  wire         cin       = flags_ff[FL_C];

  // ==========================================================================
  // Interrupt arbitration
  // RULE_24 timer request
  wire         tmr_req   = |(TMR_FLAGS & TMR_EN);
  wire         ext_req   = ext_lat_ff && ext_en_ff;
  // RULE_17 RULE_18 only at a boundary
  wire         chk       = BOUNDARY && run && !CMD_VALID;
  // RULE_08 mask blocks hardware
  wire         hw_take   = chk && !flags_ff[FL_I] && (ext_req || tmr_req);
  // RULE_19 external first
  wire         take_ext  = hw_take && ext_req;
  // RULE_20 trap ignores mask
  wire         trap_go   = cmd_go && (op == OP_TRAP);
  wire         int_start = hw_take || trap_go;

  // ==========================================================================
  // Arithmetic unit
  // RULE_07 half carry
  wire [8:0]   sum9  = {1'b0, acc_ff} + {1'b0, opd} +
                       {8'h00, cin && (op == OP_ADC)};
  wire [4:0]   half5 = {1'b0, acc_ff[3:0]} + {1'b0, opd[3:0]} +
                       {4'h0, cin && (op == OP_ADC)};
  wire [8:0]   dif9  = {1'b0, acc_ff} - {1'b0, opd} -
                       {8'h00, cin && (op == OP_SBC)};

  logic [7:0] alu_res;
  logic       alu_c;
  logic       upd_c;
  logic       upd_nz;
  always_comb begin
    alu_res = acc_ff;
    alu_c   = cin;
    upd_c   = 1'b0;
    upd_nz  = 1'b1;
    unique case (op)
      OP_LDA, OP_LDX: alu_res = opd;
      OP_ADD, OP_ADC: begin
        alu_res = sum9[7:0];
        alu_c   = sum9[8];
        upd_c   = 1'b1;
      end
      OP_SUB, OP_SBC: begin
        alu_res = dif9[7:0];
        alu_c   = dif9[8];
        upd_c   = 1'b1;
      end
      OP_AND: alu_res = acc_ff & opd;
      OP_ORA: alu_res = acc_ff | opd;
      OP_EOR: alu_res = acc_ff ^ opd;
      // RULE_10 shifts move carry
      OP_LSL: begin
        alu_res = {acc_ff[6:0], 1'b0};
        alu_c   = acc_ff[7];
        upd_c   = 1'b1;
      end
      OP_LSR: begin
        alu_res = {1'b0, acc_ff[7:1]};
        alu_c   = acc_ff[0];
        upd_c   = 1'b1;
      end
      OP_ROL: begin
        alu_res = {acc_ff[6:0], cin};
        alu_c   = acc_ff[7];
        upd_c   = 1'b1;
      end
      OP_ROR: begin
        alu_res = {cin, acc_ff[7:1]};
        alu_c   = acc_ff[0];
        upd_c   = 1'b1;
      end
      // RULE_10 bit test copies bit
      OP_BTST: begin
        alu_c  = opd[CMD.target[2:0]];
        upd_c  = 1'b1;
        upd_nz = 1'b0;
      end
      default: upd_nz = 1'b0;
    endcase
  end

  // ==========================================================================
  // Stack byte selection
  // RULE_25 push order index
  function automatic logic [7:0] stack_byte(input logic [2:0] i, input logic [12:0] pc,
                                            input logic [7:0] x, input logic [7:0] a,
                                            input logic [4:0] f);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      3'h0:    b = pc[7:0];
      3'h1:    b = {3'h0, pc[12:8]};
      3'h2:    b = x;
      3'h3:    b = a;
      default: b = {3'h0, f};
    endcase
    return b;
  endfunction : stack_byte

  // Pulls run the push order backwards
  wire [2:0]  pull_id  = count_ff - 3'h1 - step_ff;
  // RULE_13 fixed upper bits
  wire [12:0] stk_push = {STK_UPPER, sp_ff};
  wire [5:0]  sp_inc   = sp_ff + 6'h01;
  wire [12:0] stk_pull = {STK_UPPER, sp_inc};
  wire [12:0] vec_addr = vec_ff + {12'h000, step_ff[0]};

  // ==========================================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_acc   = acc_ff;
    nxt_idx   = idx_ff;
    nxt_flags = flags_ff;
    nxt_sp    = sp_ff;
    nxt_pc    = pc_ff;
    nxt_vec   = vec_ff;
    nxt_step  = step_ff;
    nxt_count = count_ff;
    nxt_jump  = jump_ff;
    unique case (state_ff)
      S_RUN: begin
        if (int_start) begin
          // RULE_16 RULE_14 five-byte entry
          nxt_state = S_PUSH;
          nxt_step  = 3'h0;
          nxt_count = INT_BYTES;
          nxt_jump  = 1'b0;
          // RULE_21 vector choice
          nxt_vec   = trap_go ? VEC_TRAP : (take_ext ? VEC_EXT : VEC_TIMER);
        end else if (cmd_go) begin
          // RULE_09 negative and zero
          if (upd_nz) begin
            nxt_flags[FL_N] = alu_res[7];
            nxt_flags[FL_Z] = (alu_res == 8'h00);
          end
          if (upd_c) nxt_flags[FL_C] = alu_c;
          if ((op == OP_ADD) || (op == OP_ADC)) nxt_flags[FL_H] = half5[4];
          // RULE_04 accumulator, RULE_05 index
          if (op == OP_LDX) nxt_idx = alu_res;
          else if (upd_nz && (op != OP_BTST)) nxt_acc = alu_res;
          unique case (op)
            // RULE_15 next fetch address
            OP_FETCH: nxt_pc = pc_ff + 13'h0001;
            OP_JUMP:  nxt_pc = CMD.target;
            OP_CALL: begin
              // RULE_14 two-byte call
              nxt_state = S_PUSH;
              nxt_step  = 3'h0;
              nxt_count = CALL_BYTES;
              nxt_jump  = 1'b1;
              nxt_vec   = CMD.target;
            end
            OP_RET, OP_IRET: begin
              nxt_state = S_PULL_RQ;
              nxt_step  = 3'h0;
              nxt_count = (op == OP_IRET) ? INT_BYTES : CALL_BYTES;
            end
            // RULE_11 reload instruction
            OP_SPRL: nxt_sp = SP_TOP;
            OP_CLI:  nxt_flags[FL_I] = 1'b0;
            OP_SEI:  nxt_flags[FL_I] = 1'b1;
            default: nxt_pc = pc_ff;
          endcase
        end
      end
      S_PUSH: begin
        // RULE_12 RULE_13 decrement after push, wraps
        nxt_sp   = sp_ff - 6'h01;
        nxt_step = step_ff + 3'h1;
        if (step_ff == count_ff - 3'h1) begin
          nxt_step = 3'h0;
          if (jump_ff) begin
            nxt_pc    = vec_ff;
            nxt_state = S_RUN;
          end else begin
            // RULE_16 mask set on entry
            nxt_flags[FL_I] = 1'b1;
            nxt_state       = S_VEC_RQ;
          end
        end
      end
      S_PULL_RQ: begin
        // RULE_12 increment before pull
        nxt_sp    = sp_inc;
        nxt_state = S_PULL_CP;
      end
      S_PULL_CP: begin
        // RULE_16 restore stacked state
        unique case (pull_id)
          3'h0:    nxt_pc[7:0]  = MEM_RDATA;
          3'h1:    nxt_pc[12:8] = MEM_RDATA[4:0];
          3'h2:    nxt_idx      = MEM_RDATA;
          3'h3:    nxt_acc      = MEM_RDATA;
          default: nxt_flags    = MEM_RDATA[4:0];
        endcase
        nxt_step  = step_ff + 3'h1;
        nxt_state = (step_ff == count_ff - 3'h1) ? S_RUN : S_PULL_RQ;
      end
      S_VEC_RQ: nxt_state = S_VEC_CP;
      S_VEC_CP: begin
        // RULE_22 upper address bits dropped
        if (step_ff[0] == 1'b0) begin
          nxt_pc[12:8] = MEM_RDATA[4:0];
          nxt_step     = 3'h1;
          nxt_state    = S_VEC_RQ;
        end else begin
          nxt_pc[7:0] = MEM_RDATA;
          nxt_step    = 3'h0;
          nxt_state   = S_RUN;
        end
      end
      default: nxt_state = S_RUN;
    endcase
  end

  // Reset lands in the vector fetch so the first instruction comes from the reset vector
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_ff <= S_VEC_RQ;
      acc_ff   <= 8'h00;
      idx_ff   <= 8'h00;
      flags_ff <= FLAGS_RST;
      // RULE_11 reset loads top
      sp_ff    <= SP_TOP;
      pc_ff    <= 13'h0000;
      vec_ff   <= VEC_RESET;
      step_ff  <= 3'h0;
      count_ff <= 3'h0;
      jump_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      acc_ff   <= nxt_acc;
      idx_ff   <= nxt_idx;
      flags_ff <= nxt_flags;
      sp_ff    <= nxt_sp;
      pc_ff    <= nxt_pc;
      vec_ff   <= nxt_vec;
      step_ff  <= nxt_step;
      count_ff <= nxt_count;
      jump_ff  <= nxt_jump;
    end
  end

  // ==========================================================================
  // External request latch
  // RULE_08 RULE_23 held until entry; EXT_REQ high in the clear cycle wins over the clear
  wire ext_clr = take_ext && !trap_go;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ext_lat_ff <= 1'b0;
      ack_ff     <= 1'b0;
    end else begin
      ext_lat_ff <= EXT_REQ || (ext_lat_ff && !ext_clr);
      ack_ff     <= ext_clr;
    end
  end

  // ==========================================================================
  // Software register port
  wire [7:0] stat = {5'h00, !run, tmr_req, ext_lat_ff};
  logic [7:0] reg_mux;
  always_comb begin
    unique case (REG_ADDR)
      R_CTRL:  reg_mux = {7'h00, ext_en_ff};
      R_ACC:   reg_mux = acc_ff;
      R_IDX:   reg_mux = idx_ff;
      R_FLAGS: reg_mux = {3'h0, flags_ff};
      R_SP:    reg_mux = {2'b11, sp_ff};
      R_PCH:   reg_mux = {3'h0, pc_ff[12:8]};
      R_PCL:   reg_mux = pc_ff[7:0];
      R_STAT:  reg_mux = stat;
      default: reg_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ext_en_ff <= 1'b0;
      rdata_ff  <= 8'h00;
    end else begin
      if (REG_WR && (REG_ADDR == R_CTRL)) ext_en_ff <= REG_WDATA[CTRL_EXT_EN];
      rdata_ff <= REG_RD ? reg_mux : 8'h00;
    end
  end

  // ==========================================================================
  // Outputs
  assign MEM_WE     = (state_ff == S_PUSH);
  assign MEM_RE     = (state_ff == S_PULL_RQ) || (state_ff == S_VEC_RQ);
  assign MEM_ADDR   = MEM_WE ? stk_push :
                      (state_ff == S_PULL_RQ) ? stk_pull :
                      (state_ff == S_VEC_RQ)  ? vec_addr : pc_ff;
  assign MEM_WDATA  = MEM_WE ? stack_byte(step_ff, pc_ff, idx_ff, acc_ff, flags_ff) : 8'h00;
  // RULE_03 RAM decode
  assign MEM_REGION = decode_region(MEM_ADDR);
  assign BUSY       = !run;
  assign INT_ACK    = ack_ff;
  // RULE_06 flags visible
  assign FLAGS      = flags_ff;
  assign ACC        = acc_ff;
  assign IDX        = idx_ff;
  assign REG_RDATA  = rdata_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence push_five_s;
    (state_ff == S_PUSH) [*5];
  endsequence
  sequence vec_two_s;
    (state_ff == S_VEC_RQ) ##1 (state_ff == S_VEC_CP) ##1
    (state_ff == S_VEC_RQ) ##1 (state_ff == S_VEC_CP);
  endsequence

  entry_seq_a: assert property (hw_take |=> push_five_s ##1 vec_two_s ##1 run) // RULE_14
    else $error("interrupt entry sequence wrong");
  mask_blocks_a: assert property (chk && flags_ff[FL_I] && !trap_go |=> run) // RULE_08
    else $error("masked request was taken");
  ext_first_a: assert property (hw_take && ext_req && tmr_req |=> vec_ff == VEC_EXT) // RULE_19
    else $error("timer beat external request");
  trap_vec_a: assert property (trap_go |=> vec_ff == VEC_TRAP && state_ff == S_PUSH) // RULE_20
    else $error("trap not taken");
  push_dec_a: assert property (MEM_WE |=> sp_ff == $past(sp_ff) - 6'h01) // RULE_12
    else $error("stack pointer not decremented");
  stack_addr_a: assert property (MEM_WE |-> MEM_ADDR[12:6] == STK_UPPER && MEM_REGION.ram) // RULE_13
    else $error("stack address outside stack page");
  mask_set_a: assert property (hw_take |-> ##6 flags_ff[FL_I]) // RULE_16
    else $error("mask not set on entry");
  latch_clr_a: assert property (ext_clr && !EXT_REQ |=> !ext_lat_ff && INT_ACK) // RULE_23
    else $error("external latch not cleared");
  half_carry_a: assert property (cmd_go && op == OP_ADD && !int_start
                                 |=> flags_ff[FL_H] == $past(half5[4])) // RULE_07
    else $error("half carry wrong");
  sp_reload_a: assert property (cmd_go && op == OP_SPRL && !int_start |=> sp_ff == SP_TOP) // RULE_11
    else $error("stack reload failed");

endmodule : cis_core_state

`default_nettype wire

// file: dv/cis_mem_model.sv
// Program memory and stack RAM model facing the core's memory port.
// Assumes read data is wanted in the cycle after the read strobe and only then.
`timescale 1ns/1ps
`default_nettype none

module cis_mem_model (
  input  wire logic        CLK,
  input  wire logic [12:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_WDATA,
  input  wire logic        MEM_WE,
  input  wire logic        MEM_RE,
  output logic      [7:0]  MEM_RDATA
);
  logic [7:0] mem_ff [8192];

  // ==========================================================================
  // Vectors: reset 0x0100, external 0x0200, timer 0x0300, trap 0x0400
  initial begin
    foreach (mem_ff[i]) mem_ff[i] = 8'h00;
    mem_ff[13'h1FF8] = 8'h03;
    mem_ff[13'h1FFA] = 8'h02;
    mem_ff[13'h1FFC] = 8'h04;
    mem_ff[13'h1FFE] = 8'h01;
  end

  // ==========================================================================
  // Access
  // Between answers the data inverts every cycle so a byte sampled one cycle late arrives inverted
  always @(posedge CLK) begin
    if (MEM_WE) mem_ff[MEM_ADDR] <= MEM_WDATA;
    MEM_RDATA <= MEM_RE ? mem_ff[MEM_ADDR] : ~MEM_RDATA;
  end
endmodule : cis_mem_model

`default_nettype wire

// file: dv/test_cis_core_state.sv
// Self-checking bench for the core state and interrupt sequencer.
// Assumes the memory model holds the vectors; the bench acts as decoder and sources.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module test_cis_core_state;
  import cis_pkg::*;
  logic        CLK, RESET, CMD_VALID, BOUNDARY, EXT_REQ, REG_WR, REG_RD;
  logic        MEM_WE, MEM_RE, BUSY, INT_ACK;
  logic [2:0]  TMR_FLAGS, TMR_EN;
  logic [3:0]  REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA, MEM_RDATA, MEM_WDATA, ACC, IDX, d;
  logic [4:0]  FLAGS, f;
  logic [12:0] MEM_ADDR, p;
  cis_cmd_t    CMD;
  cis_region_t MEM_REGION;
  logic [20:0] wq[$];
  logic [12:0] rq[$];
  int          errors = 0, tests_run = 0, acks = 0;

  cis_core_state cis_core_state_inst (.CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID),
    .CMD(CMD), .BOUNDARY(BOUNDARY), .EXT_REQ(EXT_REQ), .TMR_FLAGS(TMR_FLAGS),
    .TMR_EN(TMR_EN), .MEM_RDATA(MEM_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_REGION(MEM_REGION), .BUSY(BUSY),
    .INT_ACK(INT_ACK), .FLAGS(FLAGS), .ACC(ACC), .IDX(IDX), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
  cis_mem_model cis_mem_model_inst (.CLK(CLK), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_RDATA(MEM_RDATA));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // Record stack writes, memory reads and acknowledges for later checks
  always @(posedge CLK) begin
    if (MEM_WE) wq.push_back({MEM_ADDR, MEM_WDATA});
    if (MEM_RE) rq.push_back(MEM_ADDR);
    if (INT_ACK) acks++;
  end

  // ==========================================================================
  // Bus and command tasks
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic idle();
    int n;
    n = 0;
    #1;
    while (BUSY !== 1'b0 && n < 40) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n >= 40) begin
      errors++;
      summarize();
    end
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge CLK);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask : rd

  task automatic pc(output logic [12:0] v);
    logic [7:0] h, l;
    rd(R_PCH, h);
    rd(R_PCL, l);
    v = {h[4:0], l};
  endtask : pc

  task automatic op(input cis_op_t o, input logic [7:0] v, input logic [12:0] t);
    @(posedge CLK);
    CMD_VALID <= 1'b1; CMD <= '{o, v, t};
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    idle();
  endtask : op

  task automatic bnd();
    @(posedge CLK);
    BOUNDARY <= 1'b1;
    @(posedge CLK);
    BOUNDARY <= 1'b0;
    idle();
  endtask : bnd

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    `CHK(ACC, 8'h00)
    `CHK(IDX, 8'h00)
    `CHK(FLAGS, 5'h08)
    rd(R_SP, d); `CHK(d, 8'hFF)
    pc(p); `CHK(p, 13'h0100)
    $display("reset test done");
  endtask : t_reset

  task automatic t_alu();
    op(OP_LDA, 8'h0F, 13'h0); op(OP_ADD, 8'h01, 13'h0);
    `CHK(ACC, 8'h10)
    `CHK(FLAGS, 5'h18)
    op(OP_ADD, 8'hF0, 13'h0); `CHK(FLAGS, 5'h0B)
    op(OP_ADC, 8'h80, 13'h0); `CHK(ACC, 8'h81)
    `CHK(FLAGS, 5'h0C)
    op(OP_LSL, 8'h00, 13'h0); `CHK(FLAGS, 5'h09)
    op(OP_BTST, 8'h04, 13'h3); `CHK(FLAGS[FL_C], 1'b0)
    op(OP_LDX, 8'h80, 13'h0); `CHK(IDX, 8'h80)
    op(OP_SUB, 8'h03, 13'h0); `CHK(ACC, 8'hFF)
    `CHK(FLAGS, 5'h0D)
    op(OP_SBC, 8'hFE, 13'h0); `CHK(FLAGS, 5'h0A)
    op(OP_ORA, 8'hC3, 13'h0); op(OP_ROR, 8'h00, 13'h0); `CHK(ACC, 8'h61)
    op(OP_ROL, 8'h00, 13'h0); `CHK(FLAGS, 5'h0C)
    op(OP_LSR, 8'h00, 13'h0); `CHK(FLAGS, 5'h09)
    op(OP_EOR, 8'hFF, 13'h0); `CHK(FLAGS, 5'h0D)
    op(OP_AND, 8'h0F, 13'h0); `CHK(ACC, 8'h0E)
    $display("alu test done");
  endtask : t_alu

  task automatic t_call();
    wq.delete();
    op(OP_CALL, 8'h00, 13'h0123);
    `CHK(wq.size(), 2)
    `CHK(wq[0], {13'h00FF, 8'h00})
    `CHK(wq[1], {13'h00FE, 8'h01})
    rd(R_SP, d); `CHK(d, 8'hFD)
    pc(p); `CHK(p, 13'h0123)
    op(OP_RET, 8'h00, 13'h0); pc(p); `CHK(p, 13'h0100)
    rd(R_SP, d); `CHK(d, 8'hFF)
    op(OP_FETCH, 8'h00, 13'h0); pc(p); `CHK(p, 13'h0101)
    op(OP_JUMP, 8'h00, 13'h0100); pc(p); `CHK(p, 13'h0100)
    $display("call test done");
  endtask : t_call

  task automatic t_region();
    logic [12:0] ta[9] = '{13'h0030, 13'h004F, 13'h08FF, 13'h0900, 13'h1F10, 13'h1FEF,
                           13'h1FF0, 13'h00C0, 13'h001F};
    logic [4:0]  ra[9] = '{5'h04, 5'h04, 5'h04, 5'h00, 5'h01, 5'h01, 5'h06, 5'h08, 5'h10};
    for (int i = 0; i < 9; i++) begin
      op(OP_CALL, 8'h00, ta[i]); `CHK(MEM_ADDR, ta[i])
      `CHK(MEM_REGION, ra[i])
      op(OP_SPRL, 8'h00, 13'h0);
    end
    rd(R_SP, d); `CHK(d, 8'hFF)
    for (int i = 0; i < 33; i++) op(OP_CALL, 8'h00, 13'h0100);
    rd(R_SP, d); `CHK(d, 8'hFD)
    `CHK(wq[$][20:8], 13'h00FE)
    op(OP_SPRL, 8'h00, 13'h0);
    $display("region test done");
  endtask : t_region

  task automatic t_int();
    logic [7:0] e[5];
    wr(R_CTRL, 8'h01); wq.delete();
    @(posedge CLK); EXT_REQ <= 1'b1; TMR_FLAGS <= 3'b010; TMR_EN <= 3'b010;
    @(posedge CLK); EXT_REQ <= 1'b0;
    bnd(); `CHK(wq.size(), 0)
    rd(R_STAT, d); `CHK(d, 8'h03)
    op(OP_LDA, 8'h5A, 13'h0); op(OP_LDX, 8'hA5, 13'h0); op(OP_CLI, 8'h00, 13'h0);
    f = 5'h05; pc(p); `CHK(p, 13'h0100)
    rq.delete(); acks = 0;
    bnd(); `CHK(acks, 1)
    `CHK(rq[0], 13'h1FFA)
    `CHK(rq[1], 13'h1FFB)
    e = '{p[7:0], {3'h0, p[12:8]}, 8'hA5, 8'h5A, {3'h0, f}};
    for (int i = 0; i < 5; i++) `CHK(wq[i], {13'(13'h00FF - i), e[i]})
    `CHK(FLAGS[FL_I], 1'b1)
    rd(R_STAT, d); `CHK(d, 8'h02)
    op(OP_LDA, 8'h00, 13'h0); op(OP_IRET, 8'h00, 13'h0);
    `CHK(ACC, 8'h5A)
    `CHK(FLAGS, f)
    rq.delete(); bnd(); `CHK(rq[0], 13'h1FF8)
    @(posedge CLK); TMR_FLAGS <= 3'b000;
    pc(p); `CHK(p, 13'h0300)
    op(OP_IRET, 8'h00, 13'h0);
    $display("interrupt test done");
  endtask : t_int

  task automatic t_trap();
    op(OP_SEI, 8'h00, 13'h0); rq.delete();
    op(OP_TRAP, 8'h00, 13'h0); `CHK(rq[0], 13'h1FFC)
    pc(p); `CHK(p, 13'h0400)
    $display("trap test done");
  endtask : t_trap

  initial begin
    RESET = 1'b1; CMD_VALID = 1'b0; CMD = '0; BOUNDARY = 1'b0; EXT_REQ = 1'b0;
    TMR_FLAGS = 3'h0; TMR_EN = 3'h0; REG_WR = 1'b0; REG_RD = 1'b0;
    REG_ADDR = 4'h0; REG_WDATA = 8'h00;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    idle();
    t_reset(); t_alu(); t_call(); t_region(); t_int(); t_trap();
    summarize();
  end
endmodule : test_cis_core_state

`default_nettype wire
